// *** core/cpw_pkg.sv ***
// shared constants and types for the pwm time base and duty block
package cpw_pkg;
  // structure
  localparam int NTMR = 4;
  localparam int NCH = 2;
  localparam int DUTY_W = 10;
  localparam int TSEL_W = 2;
  // clock: pclk is the oscillator, one instruction cycle is four of its periods
  localparam int FOSC_MHZ = 50;
  localparam int OSC_PER_TCY = 4;
  localparam logic [1:0] Q_LAST = 2'(OSC_PER_TCY - 1);
  // register byte addresses
  localparam logic [7:0] ADDR_TSEL = 8'h00;
  localparam logic [7:0] ADDR_TMR_BASE = 8'h10;
  localparam logic [7:0] TMR_STRIDE = 8'h08;
  localparam logic [7:0] TMR_CTRL_OFS = 8'h00;
  localparam logic [7:0] TMR_PER_OFS = 8'h04;
  localparam logic [7:0] ADDR_CH_BASE = 8'h40;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] CH_CTRL_OFS = 8'h00;
  localparam logic [7:0] CH_HIGH_OFS = 8'h04;
  localparam logic [7:0] CH_LOW_OFS = 8'h08;
  localparam logic [7:0] CH_STAT_OFS = 8'h0c;
  // field positions
  localparam int TCTL_ON_BIT = 0;
  localparam int TCTL_PS_LSB = 1;
  localparam int TCTL_CNT_LSB = 8;
  localparam int CCTL_EN_BIT = 0;
  localparam int CCTL_FMT_BIT = 1;
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_BUF_LSB = 8;
  // prescale codes and their instruction-cycle limits
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_4 = 2'h1;
  localparam logic [1:0] PS_16 = 2'h2;
  localparam logic [1:0] PS_64 = 2'h3;
  localparam logic [5:0] PRE_LIM_1 = 6'h00;
  localparam logic [5:0] PRE_LIM_4 = 6'h03;
  localparam logic [5:0] PRE_LIM_16 = 6'h0f;
  localparam logic [5:0] PRE_LIM_64 = 6'h3f;
  // reset values
  localparam logic [7:0] PER_RST = 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h00;
  typedef logic [1:0] cpw_ps_t;
  typedef logic [7:0] cpw_byte_t;
  typedef logic [DUTY_W-1:0] cpw_duty_t;
endpackage : cpw_pkg

// *** core/cpw_reg_if.sv ***
// register access path between the apb slave and the register file
`timescale 1ns/1ns
interface cpw_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport slv (output wr_en, output addr, output wdata, input rdata, input hit);
  modport regs (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface : cpw_reg_if

// *** core/cpw_apb_slave.sv ***
// apb slave with one wait state, feeding the register file
`timescale 1ns/1ns
module cpw_apb_slave
  import cpw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register file side
  cpw_reg_if.slv rif
);
  typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_DONE = 2'b01} cpw_apb_state_t;
  typedef struct packed {
    cpw_apb_state_t state;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } cpw_apb_st_t;
  cpw_apb_st_t st_r, st_nxt;

  // the write lands on the edge where the master sees pready
  assign rif.wr_en = (st_r.state == APB_DONE) && psel && penable && pwrite && rif.hit;
  assign rif.addr = paddr;
  assign rif.wdata = pwdata;
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;

  // read data is sampled one cycle ahead so every apb output is a flop
  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      APB_IDLE: begin
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
        if (psel && penable) begin
          st_nxt.state = APB_DONE;
          st_nxt.ready = 1'b1;
          st_nxt.err = ~rif.hit;
          st_nxt.rdata = (pwrite || !rif.hit) ? 32'h0000_0000 : rif.rdata;
        end
      end
      APB_DONE: begin
        st_nxt.state = APB_IDLE;
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
      end
      default: begin
        st_nxt.state = APB_IDLE;
        st_nxt.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_access_wait |=> s_answer)
    else $error("apb answer not one cycle after access");
endmodule : cpw_apb_slave

// *** core/cpw_timebase.sv ***
// four 8-bit auto-reload timers on fosc/4 with prescaler and 10-bit time base
`timescale 1ns/1ns
module cpw_timebase
  import cpw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timer controls
  input wire logic [NTMR-1:0] tmr_on,
  input wire cpw_ps_t [NTMR-1:0] tmr_ps,
  input wire cpw_byte_t [NTMR-1:0] tmr_per,
  // time base
  output cpw_byte_t [NTMR-1:0] tmr_cnt,
  output logic [NTMR-1:0][1:0] tmr_low,
  output logic [NTMR-1:0] tmr_wrap
);
  typedef struct packed {
    logic [1:0] q;
    logic [NTMR-1:0][5:0] pre;
    cpw_byte_t [NTMR-1:0] cnt;
    logic [NTMR-1:0] wrap;
  } cpw_tb_st_t;
  cpw_tb_st_t st_r, st_nxt;
  logic [NTMR-1:0][5:0] pre_lim;

  // per-timer prescale limit and low-order time base bits
  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    assign pre_lim[i] = (tmr_ps[i] == PS_1) ? PRE_LIM_1 : (tmr_ps[i] == PS_4) ? PRE_LIM_4 :
                        (tmr_ps[i] == PS_16) ? PRE_LIM_16 : PRE_LIM_64;
    // oscillator phase at 1:1, prescaler bits otherwise
    assign tmr_low[i] = (tmr_ps[i] == PS_1) ? st_r.q : (tmr_ps[i] == PS_4) ? st_r.pre[i][1:0] :
                        (tmr_ps[i] == PS_16) ? st_r.pre[i][3:2] : st_r.pre[i][5:4];
    assign tmr_cnt[i] = st_r.cnt[i];
    assign tmr_wrap[i] = st_r.wrap[i];
  end

  // count instruction cycles; no postscaler exists, so the period only sees per and prescale
  always_comb begin
    st_nxt = st_r;
    st_nxt.q = st_r.q + 2'h1;
    st_nxt.wrap = '0;
    for (int i = 0; i < NTMR; i++) begin
      if (tmr_on[i] && (st_r.q == Q_LAST)) begin
        if (st_r.pre[i] >= pre_lim[i]) begin
          st_nxt.pre[i] = '0;
          if (st_r.cnt[i] == tmr_per[i]) begin
            st_nxt.cnt[i] = '0;
            st_nxt.wrap[i] = 1'b1;
          end else begin
            st_nxt.cnt[i] = st_r.cnt[i] + 8'h01;
          end
        end else begin
          st_nxt.pre[i] = st_r.pre[i] + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_count_clear: assert property (tmr_on[0] && st_r.q == Q_LAST && st_r.pre[0] >= pre_lim[0] &&
    st_r.cnt[0] == tmr_per[0] |=> st_r.cnt[0] == 8'h00 && tmr_wrap[0])
    else $error("timer did not clear at period match");
  a_count_step: assert property (tmr_on[1] && st_r.q == Q_LAST && st_r.pre[1] >= pre_lim[1] &&
    st_r.cnt[1] != tmr_per[1] |=> st_r.cnt[1] == $past(st_r.cnt[1]) + 8'h01)
    else $error("timer did not step by one");
  a_count_idle: assert property (!tmr_on[2] |=> $stable(st_r.cnt[2]))
    else $error("stopped timer moved");
  a_low_phase: assert property (tmr_ps[3] == PS_1 |-> tmr_low[3] == st_r.q)
    else $error("low time base bits not the oscillator phase");
endmodule : cpw_timebase

// *** core/cpw_pwm_top.sv ***
// pwm channels with selectable timer time base and double-buffered 10-bit duty
// Notes on behaviour
// - each channel picks its own time base from four 8-bit reload timers
// - a software timer-select register routes a timer to each channel
// - period is (period value + 1) times four oscillator periods times prescale
// - count equal to period clears the count on the next increment
// - pin goes high at each period start of an enabled channel unless buffered duty is zero
// - duty pair is copied into a 10-bit buffer at each period start of an enabled channel
// - no postscaler takes part in the period
// - format 0: top two duty bits from high<1:0>, low eight from low
// - format 1: bottom two duty bits from low<7:6>, top eight from high
// - duty writes any time, applied only at the next period boundary
// - high time is duty value times oscillator period times prescale
// - duty ratio is duty over 4(period+1); larger duty stays high
// - 10-bit time base is count plus phase or prescaler low bits
// - time base equal to buffered duty drives the pin low
`timescale 1ns/1ns
module cpw_pwm_top
  import cpw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm pins
  output logic [cpw_pkg::NCH-1:0] pwm_output_pin
);
  import cpw_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][TSEL_W-1:0] tsel;
    logic [NTMR-1:0] tmr_on;
    cpw_ps_t [NTMR-1:0] tmr_ps;
    cpw_byte_t [NTMR-1:0] tmr_per;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0] fmt;
    cpw_byte_t [NCH-1:0] dhi;
    cpw_byte_t [NCH-1:0] dlo;
    cpw_duty_t [NCH-1:0] dbuf;
    logic [NCH-1:0] pin;
  } cpw_top_st_t;
  cpw_top_st_t st_r, st_nxt;

  cpw_reg_if rif ();
  cpw_byte_t [NTMR-1:0] tmr_cnt;
  logic [NTMR-1:0][1:0] tmr_low;
  logic [NTMR-1:0] tmr_wrap;
  cpw_duty_t [NCH-1:0] duty_val;
  cpw_duty_t [NCH-1:0] tb;
  logic [NCH-1:0] wrap_sel;
  logic [31:0] rd_mux;
  logic rd_hit;

  // bus slave
  cpw_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.slv)
  );

  // timers run on fosc/4 by construction, which is the only clock they accept
  cpw_timebase u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .tmr_on(st_r.tmr_on),
    .tmr_ps(st_r.tmr_ps),
    .tmr_per(st_r.tmr_per),
    .tmr_cnt(tmr_cnt),
    .tmr_low(tmr_low),
    .tmr_wrap(tmr_wrap)
  );

  // per channel: time base routing and duty assembly
  for (genvar j = 0; j < NCH; j++) begin : g_ch
    assign wrap_sel[j] = tmr_wrap[st_r.tsel[j]];
    assign tb[j] = {tmr_cnt[st_r.tsel[j]], tmr_low[st_r.tsel[j]]};
    assign duty_val[j] = st_r.fmt[j] ? {st_r.dhi[j], st_r.dlo[j][7:6]}
                                     : {st_r.dhi[j][1:0], st_r.dlo[j]};
  end

  // read decode; only the listed register addresses hit, all others answer with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b0;
    if (rif.addr == ADDR_TSEL) begin
      rd_hit = 1'b1;
      rd_mux[NCH*TSEL_W-1:0] = st_r.tsel;
    end
    for (int i = 0; i < NTMR; i++) begin
      if (rif.addr == ADDR_TMR_BASE + 8'(i) * TMR_STRIDE + TMR_CTRL_OFS) begin
        rd_hit = 1'b1;
        rd_mux[TCTL_ON_BIT] = st_r.tmr_on[i];
        rd_mux[TCTL_PS_LSB +: 2] = st_r.tmr_ps[i];
        rd_mux[TCTL_CNT_LSB +: 8] = tmr_cnt[i];
      end
      if (rif.addr == ADDR_TMR_BASE + 8'(i) * TMR_STRIDE + TMR_PER_OFS) begin
        rd_hit = 1'b1;
        rd_mux[7:0] = st_r.tmr_per[i];
      end
    end
    for (int j = 0; j < NCH; j++) begin
      if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_CTRL_OFS) begin
        rd_hit = 1'b1;
        rd_mux[CCTL_EN_BIT] = st_r.ch_en[j];
        rd_mux[CCTL_FMT_BIT] = st_r.fmt[j];
      end
      if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_HIGH_OFS) begin
        rd_hit = 1'b1;
        rd_mux[7:0] = st_r.dhi[j];
      end
      if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_LOW_OFS) begin
        rd_hit = 1'b1;
        rd_mux[7:0] = st_r.dlo[j];
      end
      if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_STAT_OFS) begin
        rd_hit = 1'b1;
        rd_mux[STAT_PIN_BIT] = st_r.pin[j];
        rd_mux[STAT_BUF_LSB +: DUTY_W] = st_r.dbuf[j];
      end
    end
  end

  assign rif.rdata = rd_mux;
  assign rif.hit = rd_hit;
  assign pwm_output_pin = st_r.pin;

  // register writes and pwm pin update
  always_comb begin
    st_nxt = st_r;
    if (rif.wr_en) begin
      if (rif.addr == ADDR_TSEL) begin
        st_nxt.tsel = rif.wdata[NCH*TSEL_W-1:0];
      end
      for (int i = 0; i < NTMR; i++) begin
        if (rif.addr == ADDR_TMR_BASE + 8'(i) * TMR_STRIDE + TMR_CTRL_OFS) begin
          st_nxt.tmr_on[i] = rif.wdata[TCTL_ON_BIT];
          st_nxt.tmr_ps[i] = rif.wdata[TCTL_PS_LSB +: 2];
        end
        if (rif.addr == ADDR_TMR_BASE + 8'(i) * TMR_STRIDE + TMR_PER_OFS) begin
          st_nxt.tmr_per[i] = rif.wdata[7:0];
        end
      end
      // duty registers take writes at any time; the pin sees them only at a period start, as they load dbuf
      for (int j = 0; j < NCH; j++) begin
        if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_CTRL_OFS) begin
          st_nxt.ch_en[j] = rif.wdata[CCTL_EN_BIT];
          st_nxt.fmt[j] = rif.wdata[CCTL_FMT_BIT];
        end
        if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_HIGH_OFS) begin
          st_nxt.dhi[j] = rif.wdata[7:0];
        end
        if (rif.addr == ADDR_CH_BASE + 8'(j) * CH_STRIDE + CH_LOW_OFS) begin
          st_nxt.dlo[j] = rif.wdata[7:0];
        end
      end
    end
    // time base advances prescale oscillator periods per lsb, so high time is duty times prescale
    for (int j = 0; j < NCH; j++) begin
      if (!st_r.ch_en[j]) begin
        st_nxt.pin[j] = 1'b0;
      end else if (wrap_sel[j]) begin
        st_nxt.dbuf[j] = duty_val[j];
        st_nxt.pin[j] = (duty_val[j] != '0);
      end else if (tb[j] == st_r.dbuf[j]) begin
        st_nxt.pin[j] = 1'b0;
      end
      // a duty beyond 4(period+1) never matches, so the pin stays high
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.tmr_per <= {NTMR{PER_RST}};
      st_r.dhi <= {NCH{DUTY_RST}};
      st_r.dlo <= {NCH{DUTY_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_duty_load: assert property (st_r.ch_en[0] && wrap_sel[0] |=> st_r.dbuf[0] == $past(duty_val[0]))
    else $error("duty buffer not loaded at period start");
  a_buf_hold: assert property (!wrap_sel[0] |=> $stable(st_r.dbuf[0]))
    else $error("duty buffer changed mid period");
  a_zero_low: assert property (st_r.ch_en[0] && wrap_sel[0] && duty_val[0] == '0 |=> !pwm_output_pin[0])
    else $error("pin set with zero duty");
  a_start_high: assert property (st_r.ch_en[1] && wrap_sel[1] && duty_val[1] != '0 |=> pwm_output_pin[1])
    else $error("pin not set at period start");
  a_match_low: assert property (st_r.ch_en[0] && !wrap_sel[0] && tb[0] == st_r.dbuf[0] |=> !pwm_output_pin[0])
    else $error("pin not cleared at duty match");
  a_fmt_left: assert property (st_r.fmt[1] |-> duty_val[1][1:0] == st_r.dlo[1][7:6])
    else $error("left format low bits wrong");
  a_fmt_right: assert property (!st_r.fmt[0] |-> duty_val[0][9:8] == st_r.dhi[0][1:0])
    else $error("right format high bits wrong");
  a_wrap_tb_zero: assert property (wrap_sel[1] |-> tb[1][9:2] == 8'h00)
    else $error("period start without cleared count");
  a_buf_hold_ch1: assert property (!wrap_sel[1] |=> $stable(st_r.dbuf[1]))
    else $error("channel 1 duty buffer changed mid period");
  // with channel 0 enabled, its pin may move only at a period start or a duty match
  a_pin_keep: assert property (st_r.ch_en[0] && !wrap_sel[0] && tb[0] != st_r.dbuf[0] |=>
    pwm_output_pin[0] == $past(pwm_output_pin[0]))
    else $error("pin moved between period start and duty match");
endmodule : cpw_pwm_top

// *** tb/test_ccp_pwm_timebase_duty.sv ***
// self-checking bench for the pwm time base and duty block
`timescale 1ns/1ns
module test_ccp_pwm_timebase_duty;
  import cpw_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCH-1:0] pwm_output_pin;
  int err_count;
  int checked;
  int cyc;
  logic [31:0] rv;
  logic [3:0] ts;
  int per_v;
  int duty;
  int psv;
  int hi;
  int per;
  int ch;
  // model expectations, pushed before each measurement and popped at its compare
  int exp_q[$];

  cpw_pwm_top cpw_pwm_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_output_pin(pwm_output_pin)
  );

  // 50 mhz oscillator; the timers run from it divided by four
  always #10 pclk = ~pclk;

  // hang guard, well above the longest expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task complete_run;
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge, leaves just after one
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // outputs are read before this edge's updates land, so this is what the edge sampled
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle, so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  function automatic logic [7:0] ta(input int i, input logic [7:0] o);
    return ADDR_TMR_BASE + 8'(i) * TMR_STRIDE + o;
  endfunction : ta

  function automatic logic [7:0] ca(input int j, input logic [7:0] o);
    return ADDR_CH_BASE + 8'(j) * CH_STRIDE + o;
  endfunction : ca

  // split a duty value over the high/low pair; unused bits get noise
  task set_duty(input int j, input int fmt, input int d);
    logic [7:0] g;
    g = 8'($urandom);
    if (fmt == 0) begin
      wr(ca(j, CH_HIGH_OFS), {24'h0, g[7:2], 2'(d >> 8)});
      wr(ca(j, CH_LOW_OFS), {24'h0, 8'(d)});
    end else begin
      wr(ca(j, CH_HIGH_OFS), {24'h0, 8'(d >> 2)});
      wr(ca(j, CH_LOW_OFS), {24'h0, 2'(d), g[5:0]});
    end
  endtask : set_duty

  // time one full period from a rising edge of the pin
  task meas(input int j, output int h, output int p);
    int n;
    logic q;
    n = 0;
    q = 1'b1;
    while (n < 5000) begin
      @(negedge pclk);
      n = n + 1;
      if (q === 1'b0 && pwm_output_pin[j] === 1'b1) break;
      q = pwm_output_pin[j];
    end
    h = 0;
    p = 0;
    while (pwm_output_pin[j] === 1'b1 && p < 5000) begin
      @(negedge pclk);
      h = h + 1;
      p = p + 1;
    end
    while (pwm_output_pin[j] === 1'b0 && p < 5000) begin
      @(negedge pclk);
      p = p + 1;
    end
    @(posedge pclk);
  endtask : meas

  // count cycles at the expected level after letting w cycles pass
  task lvl(input int j, input logic v, input int w, output int cnt);
    repeat (w) @(negedge pclk);
    cnt = 0;
    repeat (w) begin
      @(negedge pclk);
      if (pwm_output_pin[j] === v) cnt = cnt + 1;
    end
    @(posedge pclk);
  endtask : lvl

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    checked = 0;
    cyc = 0;
    ts = 4'h0;
    void'($urandom(32'h5a717e2d));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and an unmapped word
    rd(ADDR_TSEL, rv);
    chk(rv, 32'h0);
    for (int i = 0; i < NTMR; i++) begin
      rd(ta(i, TMR_CTRL_OFS), rv);
      chk(rv, 32'h0);
      rd(ta(i, TMR_PER_OFS), rv);
      chk(rv, {24'h0, PER_RST});
    end
    for (int j = 0; j < NCH; j++) begin
      rd(ca(j, CH_STAT_OFS), rv);
      chk(rv, 32'h0);
    end
    begin
      logic e;
      apb(1'b0, 8'h08, 32'h0, rv, e);
      chk({31'h0, e}, 32'h1);
      chk(rv, 32'h0);
    end
    // each timer with its own prescale code routed to alternating channels
    for (int k = 0; k < NTMR; k++) begin
      ch = k % 2;
      per_v = 2 + ($urandom % 4);
      duty = 1 + ($urandom % (4 * (per_v + 1) - 1));
      psv = 1 << (2 * k);
      wr(ta(k, TMR_PER_OFS), 32'(per_v));
      wr(ta(k, TMR_CTRL_OFS), 32'(1 + (k << 1)));
      set_duty(ch, ch, duty);
      wr(ca(ch, CH_CTRL_OFS), 32'(1 + (ch << 1)));
      ts[2*ch +: 2] = 2'(k);
      wr(ADDR_TSEL, {28'h0, ts});
      exp_q.push_back(duty * psv);
      exp_q.push_back((per_v + 1) * 4 * psv);
      meas(ch, hi, per);
      chk(32'(hi), 32'(exp_q.pop_front()));
      chk(32'(per), 32'(exp_q.pop_front()));
    end
    // timer 0 at 1:1 with period value 5, on channel 0
    wr(ta(0, TMR_CTRL_OFS), 32'h1);
    wr(ta(0, TMR_PER_OFS), 32'h5);
    ts[1:0] = 2'h0;
    wr(ADDR_TSEL, {28'h0, ts});
    wr(ca(0, CH_CTRL_OFS), 32'h1);
    // zero duty never raises the pin
    set_duty(0, 0, 0);
    lvl(0, 1'b0, 60, hi);
    chk(32'(hi), 32'd60);
    // duty above 4(period+1) never lets it fall
    set_duty(0, 0, 25);
    lvl(0, 1'b1, 60, hi);
    chk(32'(hi), 32'd60);
    // a write mid-period waits for the next boundary
    wr(ta(0, TMR_PER_OFS), 32'd100);
    set_duty(0, 0, 50);
    meas(0, hi, per);
    chk(32'(hi), 32'd50);
    set_duty(0, 0, 300);
    rd(ca(0, CH_STAT_OFS), rv);
    chk({22'h0, rv[STAT_BUF_LSB +: DUTY_W]}, 32'd50);
    meas(0, hi, per);
    chk(32'(hi), 32'd300);
    chk(32'(per), 32'd404);
    // the running count never passes the period value
    for (int i = 0; i < 6; i++) begin
      rd(ta(0, TMR_CTRL_OFS), rv);
      chk(32'(rv[TCTL_CNT_LSB +: 8] <= 8'd100), 32'h1);
    end
    // a disabled channel holds its pin low
    wr(ca(0, CH_CTRL_OFS), 32'h0);
    lvl(0, 1'b0, 40, hi);
    chk(32'(hi), 32'd40);
    complete_run();
  end
endmodule : test_ccp_pwm_timebase_duty
